// File: plcd_pkg.sv
`default_nettype none
package plcd_pkg;
  // ----------------------------------------------------------------
  // character codes
  // ----------------------------------------------------------------
  localparam logic [7:0] code_null   = 8'h00;
  localparam logic [7:0] code_stx    = 8'h02;
  localparam logic [7:0] code_etx    = 8'h03;
  localparam logic [7:0] code_bs     = 8'h08;
  localparam logic [7:0] code_ht     = 8'h09;
  localparam logic [7:0] code_lf     = 8'h0A;
  localparam logic [7:0] code_ff     = 8'h0C;
  localparam logic [7:0] code_cr     = 8'h0D;
  localparam logic [7:0] code_so     = 8'h0E;
  localparam logic [7:0] code_si     = 8'h0F;
  localparam logic [7:0] code_del    = 8'h7F;
  localparam logic [7:0] code_space  = 8'h20;
  localparam logic [7:0] code_rubout = 8'h7F;   // obliteration glyph stored in a cell
  // ----------------------------------------------------------------
  // line geometry
  // ----------------------------------------------------------------
  localparam int         line_cols   = 48;
  localparam logic [5:0] col_last    = 6'd47;
  localparam logic [5:0] tab_1       = 6'd8;    // zero-based column 9
  localparam logic [5:0] tab_2       = 6'd16;   // column 17
  localparam logic [5:0] tab_3       = 6'd24;   // column 25
  localparam logic [5:0] tab_4       = 6'd32;   // column 33
  localparam logic [3:0] ff_lines    = 4'd11;
  localparam logic [3:0] lf_lines    = 4'd1;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         clk_mhz     = 100;
  localparam int         print_ms    = 750;
  localparam int         print_cycles = print_ms * 1000 * clk_mhz;
  localparam int         fifo_depth  = 4;
  localparam int         fifo_width  = 8;
  // ----------------------------------------------------------------
  // interpreter states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_print = 2'b01,
    st_del   = 2'b10
  } plcd_state_type;
endpackage : plcd_pkg
`default_nettype wire

// File: plcd_stream_if.sv
`default_nettype none
interface plcd_stream_if;
  logic [7:0] data;    // byte
  logic       valid;   // producer has a byte
  logic       ready;   // consumer takes it
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : plcd_stream_if
`default_nettype wire

// File: plcd_fifo.sv
`default_nettype none
module plcd_fifo #(
  parameter int width = 8,
  parameter int depth = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // streams
  plcd_stream_if.snk wr,
  plcd_stream_if.src rd
);
  localparam int aw = $clog2(depth);
  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  logic [width-1:0] mem [depth];   // flip-flop storage
  logic [aw-1:0]    wp;            // write index
  logic [aw-1:0]    rp;            // read index
  logic [aw:0]      cnt;           // fill level
  wire              do_wr = wr.valid && wr.ready;
  wire              do_rd = rd.valid && rd.ready;
  assign wr.ready = (cnt != (aw+1)'(depth));
  assign rd.valid = (cnt != '0);
  assign rd.data  = mem[rp];
  // pointer and level update
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (do_wr) wp <= aw'((wp + 1'b1) % depth);
      if (do_rd) rp <= aw'((rp + 1'b1) % depth);
      cnt <= cnt + (aw+1)'(do_wr) - (aw+1)'(do_rd);
    end
  end
  // data write
  always_ff @(posedge clk) begin
    if (do_wr) mem[wp] <= wr.data;
  end
endmodule : plcd_fifo
`default_nettype wire

// File: plcd_decoder.sv
`default_nettype none
module plcd_decoder #(
  parameter int print_cycles = plcd_pkg::print_cycles
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // host parallel port
  input  wire logic [7:0]  host_data,
  input  wire logic        host_strobe_n,
  output var  logic        host_ack_n,
  output var  logic        host_busy,
  // print engine requests
  output var  logic        eng_print,
  output var  logic        eng_advance,
  output var  logic [3:0]  eng_lines,
  output var  logic        eng_inverted,
  output var  logic [383:0] eng_line,
  output var  logic [47:0] eng_alt_set,
  // state view
  output var  logic [5:0]  col_addr,
  output var  logic        alt_set,
  output var  logic        inverted
);
  // ----------------------------------------------------------------
  // host handshake front end
  // ----------------------------------------------------------------
  // a byte is taken on the sampled falling edge of the strobe,
  // never while a print cycle holds the port busy;
  // the strobe must stay low across two edges so the host
  // sees the one-cycle acknowledge before it lets go
  plcd_stream_if in_s ();
  plcd_stream_if out_s ();
  logic strobe_q;      // previous strobe level
  logic strobe_fall;   // falling strobe takes a byte
  assign strobe_fall = strobe_q && !host_strobe_n;
  assign in_s.data   = host_data;
  assign in_s.valid  = strobe_fall && !host_busy;
  // sample strobe and acknowledge each accepted byte
  always_ff @(posedge clk) begin
    if (!nrst) begin
      strobe_q   <= 1'b1;
      host_ack_n <= 1'b1;
    end else begin
      strobe_q   <= host_strobe_n;
      host_ack_n <= !(in_s.valid && in_s.ready);
    end
  end
  // small queue between port and interpreter: the port acknowledges
  // at once while the interpreter may still be busy with a delete;
  // bytes left in it wait out a print cycle
  plcd_fifo #(.width(plcd_pkg::fifo_width), .depth(plcd_pkg::fifo_depth)) u_fifo (
    .clk  (clk),
    .nrst (nrst),
    .wr   (in_s),
    .rd   (out_s)
  );
  // ----------------------------------------------------------------
  // interpreter state
  // ----------------------------------------------------------------
  // line register cells hold the raw code; the second-set flag
  // travels beside each cell so a set switch may fall mid-line;
  // orientation is latched per line, the pending value waits for the next
  plcd_pkg::plcd_state_type state;   // current state
  logic [7:0]  line_q [48];          // line register
  logic [47:0] alt_q;                // cell came from second set
  logic [31:0] timer;                // print cycle counter
  logic        after_cr;             // last code was carriage return
  logic        pend_inv;             // orientation for next line
  logic        line_empty;           // nothing loaded yet
  wire  [7:0]  c = out_s.data;
  wire         take = out_s.valid && out_s.ready;
  assign out_s.ready = (state == plcd_pkg::st_idle);
  // ----------------------------------------------------------------
  // decode of the byte at the FIFO head
  // ----------------------------------------------------------------
  // decode is purely combinational on the queue head;
  // at most one flag is true, so the branch order below
  // matters only for readability
  wire is_null  = (c == plcd_pkg::code_null);
  wire is_bs    = (c == plcd_pkg::code_bs);
  wire is_so    = (c == plcd_pkg::code_so);
  wire is_si    = (c == plcd_pkg::code_si);
  wire is_stx   = (c == plcd_pkg::code_stx);
  wire is_etx   = (c == plcd_pkg::code_etx);
  wire is_ht    = (c == plcd_pkg::code_ht);
  wire is_lf    = (c == plcd_pkg::code_lf);
  wire is_ff    = (c == plcd_pkg::code_ff);
  wire is_cr    = (c == plcd_pkg::code_cr);
  wire is_del   = (c == plcd_pkg::code_del);
  wire is_print = (c[6:5] != 2'b00) && !is_del && !c[7]; // 95-entry set
  wire at_end   = (col_addr == plcd_pkg::col_last);
  // next tab stop, or stay put at or past the last one
  logic [5:0] next_tab;
  assign next_tab = (col_addr < plcd_pkg::tab_1) ? plcd_pkg::tab_1 :
                    (col_addr < plcd_pkg::tab_2) ? plcd_pkg::tab_2 :
                    (col_addr < plcd_pkg::tab_3) ? plcd_pkg::tab_3 :
                    (col_addr < plcd_pkg::tab_4) ? plcd_pkg::tab_4 : col_addr;
  wire timer_done = (timer == 32'(print_cycles - 1));
  // ----------------------------------------------------------------
  // main interpreter
  // ----------------------------------------------------------------
  // one byte is consumed per clock while idle;
  // delete takes a second cycle to lay down the rubout;
  // return and a printable character written in the last column start a print cycle
  // during which the queue is not read and the port reports busy;
  // at the end of the print the line is blanked, the column returns
  // to the left margin and a pending orientation takes effect
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state        <= plcd_pkg::st_idle;
      col_addr     <= '0;
      alt_set      <= 1'b0;
      inverted     <= 1'b0;
      pend_inv     <= 1'b0;
      after_cr     <= 1'b0;
      line_empty   <= 1'b1;
      timer        <= '0;
      host_busy    <= 1'b0;
      eng_print    <= 1'b0;
      eng_advance  <= 1'b0;
      eng_lines    <= '0;
      eng_inverted <= 1'b0;
      alt_q        <= '0;
      eng_alt_set  <= '0;
      for (int i = 0; i < plcd_pkg::line_cols; i++) line_q[i] <= plcd_pkg::code_space;
    end else begin
      eng_print   <= 1'b0;
      eng_advance <= 1'b0;
      case (state)
        plcd_pkg::st_idle: begin
          if (take) begin
            after_cr <= 1'b0;
            if (is_null) begin
              after_cr <= after_cr;
            end else if (is_so) begin
              alt_set <= 1'b1;
            end else if (is_si) begin
              alt_set <= 1'b0;
            end else if (is_stx) begin
              pend_inv <= 1'b1;
              if (line_empty) inverted <= 1'b1;
            end else if (is_etx) begin
              pend_inv <= 1'b0;
              if (line_empty) inverted <= 1'b0;
            end else if (is_bs) begin
              if (col_addr != '0) begin
                col_addr <= col_addr - 6'd1;
                line_q[col_addr - 6'd1] <= plcd_pkg::code_space;
                // removed cell becomes a blank of the normal set
                alt_q[col_addr - 6'd1]  <= 1'b0;
              end
            end else if (is_del) begin
              if (col_addr != '0) begin
                col_addr <= col_addr - 6'd1;
                line_q[col_addr - 6'd1] <= plcd_pkg::code_space;
                state <= plcd_pkg::st_del;
              end
            end else if (is_ht) begin
              col_addr   <= next_tab;
              line_empty <= 1'b0;
            end else if (is_lf) begin
              if (!after_cr) begin
                eng_advance <= 1'b1;
                eng_lines   <= plcd_pkg::lf_lines;
              end
            end else if (is_ff) begin
              eng_advance <= 1'b1;
              eng_lines   <= plcd_pkg::ff_lines;
            end else if (is_cr) begin
              after_cr  <= 1'b1;
              state     <= plcd_pkg::st_print;
              host_busy <= 1'b1;
              eng_print <= 1'b1;
              eng_lines <= plcd_pkg::lf_lines;
              eng_inverted <= inverted;
              eng_alt_set  <= alt_q;
            end else if (is_print) begin
              line_q[col_addr] <= c;
              alt_q[col_addr]  <= alt_set;
              line_empty       <= 1'b0;
              if (at_end) begin
                state        <= plcd_pkg::st_print;
                host_busy    <= 1'b1;
                eng_print    <= 1'b1;
                eng_lines    <= plcd_pkg::lf_lines;
                eng_inverted <= inverted;
                eng_alt_set  <= {alt_set, alt_q[46:0]};
              end else begin
                col_addr <= col_addr + 6'd1;
              end
            end
          end
        end
        // second step of a delete: rubout in the cleared cell,
        // then step back to where the column was
        plcd_pkg::st_del: begin
          line_q[col_addr] <= plcd_pkg::code_rubout;
          alt_q[col_addr]  <= 1'b0;
          col_addr         <= col_addr + 6'd1;
          state            <= plcd_pkg::st_idle;
        end
        // count out the print cycle; nothing is taken meanwhile,
        // the queue holds any byte that slipped in just before
        plcd_pkg::st_print: begin
          if (timer_done) begin
            timer      <= '0;
            state      <= plcd_pkg::st_idle;
            host_busy  <= 1'b0;
            col_addr   <= '0;
            line_empty <= 1'b1;
            inverted   <= pend_inv;
            alt_q      <= '0;
            for (int i = 0; i < plcd_pkg::line_cols; i++) line_q[i] <= plcd_pkg::code_space;
          end else begin
            timer <= timer + 32'd1;
          end
        end
        default: state <= plcd_pkg::st_idle;
      endcase
    end
  end
  // the image is taken in the same edge as the print request so the
  // engine never sees the blanking at the end of the cycle
  // latch line image for the engine when a print starts
  always_ff @(posedge clk) begin
    if (!nrst) begin
      eng_line <= '0;
    end else if (state == plcd_pkg::st_idle && take && (is_cr || (is_print && at_end))) begin
      for (int i = 0; i < plcd_pkg::line_cols; i++)
        eng_line[i*8 +: 8] <= (is_print && i == 47) ? c : line_q[i];
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // properties watch the interpreter at the queue head;
  // take already implies the idle state;
  // cover points at the end mark the main scenarios
  property p_busy_print;
    @(posedge clk) disable iff (!nrst) $rose(eng_print) |-> host_busy;
  endproperty
  a_busy_print: assert property (p_busy_print) else $error("busy not set at print");
  property p_no_take_busy;
    @(posedge clk) disable iff (!nrst) host_busy |=> host_ack_n;
  endproperty
  a_no_take_busy: assert property (p_no_take_busy) else $error("byte taken in print");
  property p_ff_lines;
    @(posedge clk) disable iff (!nrst) (state == plcd_pkg::st_idle && take && is_ff)
      |=> eng_advance && eng_lines == plcd_pkg::ff_lines;
  endproperty
  a_ff_lines: assert property (p_ff_lines) else $error("form feed lines wrong");
  property p_lf_after_cr;
    @(posedge clk) disable iff (!nrst) (take && is_lf && after_cr) |=> !eng_advance;
  endproperty
  a_lf_after_cr: assert property (p_lf_after_cr) else $error("lf after cr not ignored");
  property p_so_alt;
    @(posedge clk) disable iff (!nrst) (state == plcd_pkg::st_idle && take && is_so) |=> alt_set;
  endproperty
  a_so_alt: assert property (p_so_alt) else $error("shift out ignored");
  property p_si_norm;
    @(posedge clk) disable iff (!nrst) (state == plcd_pkg::st_idle && take && is_si) |=> !alt_set;
  endproperty
  a_si_norm: assert property (p_si_norm) else $error("shift in ignored");
  property p_null_keep;
    @(posedge clk) disable iff (!nrst) (state == plcd_pkg::st_idle && take && is_null)
      |=> $stable(col_addr) && $stable(alt_set) && $stable(inverted);
  endproperty
  a_null_keep: assert property (p_null_keep) else $error("null changed state");
  property p_inv_stable;
    @(posedge clk) disable iff (!nrst) (state == plcd_pkg::st_idle && !line_empty)
      |=> $stable(inverted);
  endproperty
  a_inv_stable: assert property (p_inv_stable) else $error("orientation changed mid-line");
  property p_del_back;
    @(posedge clk) disable iff (!nrst)
      (state == plcd_pkg::st_idle && take && is_del && col_addr != 0)
      |=> ##1 col_addr == $past(col_addr, 2);
  endproperty
  a_del_back: assert property (p_del_back) else $error("delete did not return");
  property p_bs_back;
    @(posedge clk) disable iff (!nrst) (take && is_bs && col_addr != '0)
      |=> col_addr == $past(col_addr) - 6'd1;
  endproperty
  a_bs_back: assert property (p_bs_back) else $error("backspace missed");
  property p_ht_first;
    @(posedge clk) disable iff (!nrst) (take && is_ht && col_addr < plcd_pkg::tab_1)
      |=> col_addr == plcd_pkg::tab_1;
  endproperty
  a_ht_first: assert property (p_ht_first) else $error("tab missed first stop");
  property p_lf_adv;
    @(posedge clk) disable iff (!nrst) (take && is_lf && !after_cr)
      |=> eng_advance && !eng_print && eng_lines == plcd_pkg::lf_lines;
  endproperty
  a_lf_adv: assert property (p_lf_adv) else $error("line feed did not advance");
  property p_cr_print;
    @(posedge clk) disable iff (!nrst) (take && is_cr)
      |=> eng_print && host_busy && eng_lines == plcd_pkg::lf_lines;
  endproperty
  a_cr_print: assert property (p_cr_print) else $error("return did not print");
  property p_print_clear;
    @(posedge clk) disable iff (!nrst) (state == plcd_pkg::st_print && timer_done)
      |=> col_addr == '0 && line_empty && !host_busy;
  endproperty
  a_print_clear: assert property (p_print_clear) else $error("line not cleared");
  property p_auto_print;
    @(posedge clk) disable iff (!nrst) (take && is_print && at_end)
      |=> eng_print && host_busy && col_addr == plcd_pkg::col_last;
  endproperty
  a_auto_print: assert property (p_auto_print) else $error("no print at line end");
  property p_ack_pulse;
    @(posedge clk) disable iff (!nrst) !host_ack_n |=> host_ack_n;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  c_print: cover property (@(posedge clk) disable iff (!nrst) eng_print);
  c_ff:    cover property (@(posedge clk) disable iff (!nrst) take && is_ff);
  c_del:   cover property (@(posedge clk) disable iff (!nrst) state == plcd_pkg::st_del);
  c_lf_skip: cover property (@(posedge clk) disable iff (!nrst) take && is_lf && after_cr);
  c_auto:    cover property (@(posedge clk) disable iff (!nrst) take && is_print && at_end);
endmodule : plcd_decoder
`default_nettype wire

// File: plcd_host_model.sv
`default_nettype none
// host side of the parallel port: one byte per strobe, held until ack or six clocks
module plcd_host_model #(
  parameter int gap = 8  // idle cycles after each byte, shortened load time
) (
  // clock
  input  wire logic       clk,
  // parallel port
  output var  logic [7:0] host_data,
  output var  logic       host_strobe_n,
  input  wire logic       host_ack_n,
  input  wire logic       host_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  initial begin
    host_data     = 8'h00;
    host_strobe_n = 1'b1;
  end
  // ----------------------------------------------------------------
  // byte transfer; wait_idle low lets a scenario strobe into a busy port
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] b, input bit wait_idle, output bit acked);
    int n;
    acked = 1'b0;
    n     = 0;
    while (wait_idle && host_busy === 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    @(negedge clk);
    host_data     = b;
    host_strobe_n = 1'b0;
    for (n = 0; n < 6 && !acked; n++) begin
      @(posedge clk);
      acked = (host_ack_n === 1'b0);
    end
    @(negedge clk);
    host_strobe_n = 1'b1;
    host_data     = ~b;    // released lines no longer show the byte
    repeat (gap) @(posedge clk);
  endtask : send
endmodule : plcd_host_model
`default_nettype wire

// File: test_printer_line_control_decoder.sv
`default_nettype none
module test_printer_line_control_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int pc = 50;  // shortened print cycle
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic         clk = 1'b0;
  logic         nrst = 1'b0;
  logic [7:0]   host_data;
  logic         host_strobe_n, host_ack_n, host_busy;
  logic         eng_print, eng_advance, eng_inverted, alt_set, inverted;
  logic [3:0]   eng_lines, alines;
  logic [383:0] eng_line, pline;
  logic [47:0]  eng_alt_set, palt;
  logic [5:0]   col_addr;
  logic         pinv;
  int           error_cnt = 0, compares = 0, cyc = 0, prints = 0, advs = 0, busy_len = 0;
  bit           ack;
  int           a, i;
  // row: code, column, alt set, inverted, advance lines (0 none)
  typedef struct packed {
    logic [7:0] code;
    logic [5:0] col;
    logic       alt;
    logic       inv;
    logic [3:0] adv;
  } plcd_row_type;
  plcd_row_type rows [15] = '{
    '{8'h41, 6'd1, 1'b0, 1'b0, 4'h0}, '{8'h00, 6'd1, 1'b0, 1'b0, 4'h0},
    '{8'h0E, 6'd1, 1'b1, 1'b0, 4'h0}, '{8'h42, 6'd2, 1'b1, 1'b0, 4'h0},
    '{8'h0F, 6'd2, 1'b0, 1'b0, 4'h0}, '{8'h08, 6'd1, 1'b0, 1'b0, 4'h0},
    '{8'h09, 6'd8, 1'b0, 1'b0, 4'h0}, '{8'h09, 6'd16, 1'b0, 1'b0, 4'h0},
    '{8'h09, 6'd24, 1'b0, 1'b0, 4'h0}, '{8'h09, 6'd32, 1'b0, 1'b0, 4'h0},
    '{8'h09, 6'd32, 1'b0, 1'b0, 4'h0}, '{8'h7F, 6'd32, 1'b0, 1'b0, 4'h0},
    '{8'h0A, 6'd32, 1'b0, 1'b0, 4'h1}, '{8'h0C, 6'd32, 1'b0, 1'b0, 4'hB},
    '{8'hC1, 6'd32, 1'b0, 1'b0, 4'h0}};
  // ----------------------------------------------------------------
  // clock, design and host
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  plcd_decoder #(.print_cycles(pc)) dut (
    .clk(clk), .nrst(nrst), .host_data(host_data), .host_strobe_n(host_strobe_n),
    .host_ack_n(host_ack_n), .host_busy(host_busy), .eng_print(eng_print),
    .eng_advance(eng_advance), .eng_lines(eng_lines), .eng_inverted(eng_inverted),
    .eng_line(eng_line), .eng_alt_set(eng_alt_set), .col_addr(col_addr),
    .alt_set(alt_set), .inverted(inverted));
  plcd_host_model host (
    .clk(clk), .host_data(host_data), .host_strobe_n(host_strobe_n),
    .host_ack_n(host_ack_n), .host_busy(host_busy));
  // ----------------------------------------------------------------
  // engine monitor and timeout
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (eng_print === 1'b1) begin
      prints++;
      pline = eng_line;
      palt  = eng_alt_set;
      pinv  = eng_inverted;
    end
    if (eng_advance === 1'b1) begin
      advs++;
      alines = eng_lines;
    end
    if (host_busy === 1'b1) busy_len++;
    if (cyc == 6000) begin
      error_cnt++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic put(input logic [7:0] b);
    host.send(b, 1'b1, ack);
    check(ack, 1'b1);
  endtask : put
  task automatic wait_idle();
    int n;
    for (n = 0; n < 1000 && host_busy === 1'b1; n++) @(posedge clk);
    repeat (2) @(negedge clk);
  endtask : wait_idle
  task automatic summarize();
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    foreach (rows[r]) begin
      a = advs;
      put(rows[r].code);
      check(col_addr, rows[r].col);
      check({alt_set, inverted}, {rows[r].alt, rows[r].inv});
      check(advs - a, (rows[r].adv != 4'h0));
      if (rows[r].adv != 4'h0) check(alines, rows[r].adv);
    end
    check(prints, 0);
    // return prints the line, busy refuses a strobe
    busy_len = 0;
    put(8'h0D);
    check(prints, 1);
    check({pline[7:0], pline[15:8], pline[255:248]}, {8'h41, 8'h20, 8'h7F});
    check(palt[1:0], 2'b00);
    check(host_busy, 1'b1);
    host.send(8'h5A, 1'b0, ack);
    check(ack, 1'b0);
    wait_idle();
    check((busy_len >= pc) && (busy_len <= pc + 2), 1'b1);
    check(col_addr, 6'd0);
    a = advs;
    put(8'h0A);
    check(advs, a);
    // orientation on an empty line
    put(8'h02);
    check(inverted, 1'b1);
    put(8'h0E);
    put(8'h43);
    put(8'h0F);
    put(8'h0D);
    wait_idle();
    check({pinv, pline[7:0], pline[15:8]}, {1'b1, 8'h43, 8'h20});
    check(palt[1:0], 2'b01);
    put(8'h03);
    check(inverted, 1'b0);
    // a full line prints on its own
    for (i = 0; i < 47; i++) put(8'h30 + 8'(i % 10));
    check(col_addr, 6'd47);
    put(8'h39);
    check(prints, 3);
    wait_idle();
    check({pline[383:376], pline[375:368], col_addr}, {8'h39, 8'h36, 6'd0});
    // reset in mid-line
    put(8'h0E);
    put(8'h44);
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    check({col_addr, alt_set, inverted, host_busy, host_ack_n}, {6'd0, 4'b0001});
    nrst = 1'b1;
    put(8'h45);
    check({col_addr, alt_set, inverted}, {6'd1, 2'b00});
    summarize();
  end
endmodule : test_printer_line_control_decoder
`default_nettype wire
